/* File: fpc_pin_ctrl.sv */
`timescale 1ns/1ps
`include "fpc_regs.svh"
module fpc_pin_ctrl (
   input wire logic clk_sys_in,
   input wire logic rst_b_in,
   input wire logic bus_mode_strap_in,
   input wire logic encoding_pin_in,
   output logic encoding_pin_out,
   output logic encoding_pin_oe_out,
   input wire logic doc_write_in,
   input wire logic [7:0] doc_data_in,
   input wire logic dsr_write_in,
   input wire logic [7:0] dsr_data_in,
   input wire logic ccr_write_in,
   input wire logic [7:0] ccr_data_in,
   input wire logic mode_write_in,
   input wire logic [7:0] mode_data_in,
   input wire logic cfg_write_in,
   input wire logic [7:0] cfg_data_in,
   input wire logic lock_write_in,
   input wire logic lock_data_in,
   input wire logic timing_write_in,
   input wire logic [7:0] timing_data_in,
   input wire logic [7:0] function_enable_in,
   input wire logic exec_done_in,
   input wire logic xfer_ready_in,
   input wire logic non_dma_in,
   input wire logic double_density_in,
   input wire logic diag_in,
   output logic controller_interrupt_out,
   output logic [1:0] motor_enable_b_out,
   output logic [7:0] drive_output_control_out,
   output logic [7:0] data_rate_select_out,
   output logic [7:0] configuration_control_out,
   output logic [7:0] mode_params_out,
   output logic [7:0] config_params_out,
   output logic lock_out,
   output logic [7:0] timing_params_out,
   output fpc_pkg::fpc_host_mode_t host_mode_out
);
   import fpc_pkg::*;

   typedef struct packed {
      logic in_reset;
      fpc_host_mode_t host_mode;
      logic [7:0] doc;
      logic [7:0] dsr;
      logic [7:0] configuration_control_reg;
      logic [7:0] mode;
      logic [7:0] cfg;
      logic lock;
      logic [7:0] timing;
      logic irq;
      logic [1:0] motor_b;
      logic enc;
      logic enc_oe;
   } fpc_state_t;

   fpc_state_t state;
   fpc_state_t next_state;
   logic [1:0] pins_sync;
   logic strap_s;
   logic enc_s;

   // Pins from outside pass two flops first
   fpc_sync #(.WIDTH(2)) u_sync (
      .clk_sys_in(clk_sys_in),
      .async_in({bus_mode_strap_in, encoding_pin_in}),
      .sync_out(pins_sync)
   );
   assign strap_s = pins_sync[1];
   assign enc_s = pins_sync[0];

   // Motor pattern from the drive output register, two or four drive coding
   function automatic logic [1:0] motor_code(input logic [7:0] doc, input logic four);
      logic [1:0] sel;
      logic on;
      sel = doc[`FPC_DOC_DRIVE_HI:`FPC_DOC_DRIVE_LO];
      on = doc[`FPC_DOC_MOTOR_LO + 32'(sel)];
      if (four) begin
         motor_code = on ? ~sel : 2'h3; // Encoded drive number, idle when off
      end else begin
         motor_code = ~doc[`FPC_DOC_MOTOR_LO + 1:`FPC_DOC_MOTOR_LO];
      end
   endfunction

   // Next-state logic
   always_comb begin
      next_state = state;
      next_state.in_reset = 1'b0;
      if (state.in_reset) begin
         // Strap sampled on the first cycle after release
         if (strap_s) begin
            next_state.host_mode = FPC_CLASSIC;
         end else begin
            next_state.host_mode = enc_s ? FPC_ALTERNATE : FPC_COMPACT;
         end
      end
      if (doc_write_in) begin
         next_state.doc = doc_data_in;
      end
      if (dsr_write_in) begin
         next_state.dsr = dsr_data_in;
      end
      if (ccr_write_in) begin
         next_state.configuration_control_reg = ccr_data_in;
      end
      if (mode_write_in && !state.lock) begin
         next_state.mode = mode_data_in;
      end
      if (cfg_write_in && !state.lock) begin
         next_state.cfg = cfg_data_in;
      end
      if (lock_write_in) begin
         next_state.lock = lock_data_in;
      end
      if (timing_write_in) begin
         next_state.timing = timing_data_in;
      end
      // Interrupt source and gating
      next_state.irq = (exec_done_in || (non_dma_in && xfer_ready_in))
         && ((state.host_mode == FPC_ALTERNATE)
         || state.doc[`FPC_DOC_INT_EN_BIT]);
      next_state.motor_b = motor_code(state.doc, function_enable_in[`FPC_FER_FOUR_DRIVE_BIT]);
      next_state.enc_oe = 1'b1;
      next_state.enc = state.mode[`FPC_MODE_DIAG_BIT] ? diag_in : double_density_in;
   end

   // Register the state; timing parameters survive chip reset
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         state.in_reset <= 1'b1;
         state.host_mode <= FPC_CLASSIC;
         state.doc <= `FPC_DOC_RESET;
         state.dsr <= `FPC_DSR_RESET;
         state.configuration_control_reg <= `FPC_CCR_RESET;
         state.mode <= `FPC_MODE_RESET;
         state.cfg <= `FPC_CFG_RESET;
         state.lock <= `FPC_LOCK_RESET;
         state.timing <= state.timing;
         state.irq <= 1'b0;
         state.motor_b <= 2'h3;
         state.enc <= 1'b0;
         state.enc_oe <= 1'b0; // Pin released so the strap can be read
      end else begin
         state <= next_state;
      end
   end

   assign controller_interrupt_out = state.irq;
   assign motor_enable_b_out = state.motor_b;
   assign encoding_pin_out = state.enc;
   assign encoding_pin_oe_out = state.enc_oe;
   assign drive_output_control_out = state.doc;
   assign data_rate_select_out = state.dsr;
   assign configuration_control_out = state.configuration_control_reg;
   assign mode_params_out = state.mode;
   assign config_params_out = state.cfg;
   assign lock_out = state.lock;
   assign timing_params_out = state.timing;
   assign host_mode_out = state.host_mode;

   // Checks
   sequence seq_event;
      exec_done_in || (non_dma_in && xfer_ready_in);
   endsequence

   AST_IRQ_ALT: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      (state.host_mode == FPC_ALTERNATE && !state.in_reset) ##0 seq_event |=> controller_interrupt_out)
      else $error("interrupt missing in alternate mode");
   AST_IRQ_GATE: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      (state.host_mode != FPC_ALTERNATE && !state.doc[`FPC_DOC_INT_EN_BIT]) |=> !controller_interrupt_out)
      else $error("interrupt not gated");
   AST_IRQ_CAUSE: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      controller_interrupt_out |-> $past(exec_done_in || (non_dma_in && xfer_ready_in)))
      else $error("interrupt without cause");
   AST_MOTOR_TWO: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      !function_enable_in[`FPC_FER_FOUR_DRIVE_BIT]
      |=> motor_enable_b_out == ~$past(state.doc[`FPC_DOC_MOTOR_LO + 1:`FPC_DOC_MOTOR_LO]))
      else $error("motor enables wrong");
   AST_RESET_OUT: assert property (@(posedge clk_sys_in)
      !rst_b_in |=> (!controller_interrupt_out && motor_enable_b_out == 2'h3 && !encoding_pin_out))
      else $error("outputs active after reset");
   AST_MODE_HOLD: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      (!state.in_reset && !$past(state.in_reset)) |-> $stable(host_mode_out))
      else $error("host mode changed");
   AST_ENC_OUT: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      !state.mode[`FPC_MODE_DIAG_BIT] |=> encoding_pin_out == $past(double_density_in))
      else $error("encoding pin wrong");
   AST_DIAG_OUT: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      state.mode[`FPC_MODE_DIAG_BIT] |=> encoding_pin_out == $past(diag_in))
      else $error("diagnostic route wrong");
   // Strap low in reset: pin level picks alternate or compact mode at release
   AST_MODE_STRAP: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      (state.in_reset && !strap_s) |=> host_mode_out == ($past(enc_s) ? FPC_ALTERNATE : FPC_COMPACT))
      else $error("strap mode not taken");
   // Strap high in reset keeps the classic mode
   AST_MODE_CLASSIC: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      (state.in_reset && strap_s) |=> host_mode_out == FPC_CLASSIC)
      else $error("classic mode not taken");
   // Four-drive coding with drive 3 selected shows its inverted motor bit on both lines
   AST_MOTOR_FOUR: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      (function_enable_in[`FPC_FER_FOUR_DRIVE_BIT] && state.doc[`FPC_DOC_DRIVE_HI:`FPC_DOC_DRIVE_LO] == 2'h3)
      |=> motor_enable_b_out == {2{!$past(state.doc[`FPC_DOC_MOTOR_HI])}})
      else $error("four drive motor coding wrong");
   // Reset restores the register defaults of every register but timing
   AST_REGS_RESET: assert property (@(posedge clk_sys_in)
      !rst_b_in |=> (drive_output_control_out == `FPC_DOC_RESET && data_rate_select_out == `FPC_DSR_RESET
      && configuration_control_out == `FPC_CCR_RESET && mode_params_out == `FPC_MODE_RESET
      && config_params_out == `FPC_CFG_RESET && lock_out == `FPC_LOCK_RESET))
      else $error("register defaults wrong after reset");
   // Once out of reset the encoding pin is driven
   AST_ENC_DRIVEN: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      !state.in_reset |-> encoding_pin_oe_out)
      else $error("encoding pin not driven");
endmodule

/* File: fpc_pkg.sv */
package fpc_pkg;
   typedef enum logic [1:0] {
      FPC_CLASSIC,
      FPC_COMPACT,
      FPC_ALTERNATE
   } fpc_host_mode_t;
endpackage

/* File: fpc_regs.svh */
`ifndef FPC_REGS_SVH
`define FPC_REGS_SVH
// Drive output control register layout
`define FPC_DOC_INT_EN_BIT 3
`define FPC_DOC_MOTOR_LO 4
`define FPC_DOC_MOTOR_HI 7
`define FPC_DOC_DRIVE_LO 0
`define FPC_DOC_DRIVE_HI 1
`define FPC_DOC_RESET_BIT 2
// Function enable bit that selects four-drive motor encoding
`define FPC_FER_FOUR_DRIVE_BIT 4
// Reset values
`define FPC_DOC_RESET 8'h00
`define FPC_DSR_RESET 8'h02
`define FPC_CCR_RESET 8'h02
`define FPC_MODE_RESET 8'h00
`define FPC_CFG_RESET 8'h00
`define FPC_LOCK_RESET 1'h0
// Mode command field that routes the diagnostic signal to the encoding pin
`define FPC_MODE_DIAG_BIT 0
`endif

/* File: fpc_strap_model.sv */
`timescale 1ns/1ps
// Strap resistor on the shared encoding pin, seen by the device in reset
module fpc_strap_model (
   input wire logic pull_high_in,
   input wire logic encoding_pin_out,
   input wire logic encoding_pin_oe_out,
   output logic encoding_pin_in
);
   // Device drives the pin out of reset, else the resistor level shows
   assign encoding_pin_in = encoding_pin_oe_out ? encoding_pin_out : pull_high_in;
endmodule

/* File: fpc_sync.sv */
`timescale 1ns/1ps
// Two flip-flop synchroniser for a group of pin inputs
module fpc_sync #(
   parameter int WIDTH = 4
) (
   input wire logic clk_sys_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } fpc_sync_state_t;
   fpc_sync_state_t state;
   fpc_sync_state_t next_state;

   // The first stage feeds only the second stage
   always_comb begin
      next_state = state;
      next_state.meta = async_in;
      next_state.stable = state.meta;
   end

   // Register the state; no reset, so strap levels keep flowing while the chip is held in reset
   always_ff @(posedge clk_sys_in) begin
      state <= next_state;
   end

   assign sync_out = state.stable;
endmodule

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
   import fpc_pkg::*;
   typedef struct {int id; logic [7:0] exp;} fpc_note_t;
   logic clk_sys_in = 0, rst_b_in = 0, strap = 1, pull = 1, exd = 0, xrdy = 0, ndma = 0, dd = 0, diag = 0;
   logic [6:0] we = 7'h00;
   logic [7:0] wd = 8'h00, fe = 8'h00;
   logic enc_in, enc_out, enc_oe, irq, lock;
   logic [1:0] mot_b;
   logic [7:0] doc, dsr, configuration_control_reg, mpar, cpar, tpar;
   logic [7:0] dflt[6] = '{8'h00, 8'h02, 8'h02, 8'h00, 8'h00, 8'h00};
   fpc_host_mode_t hmode;
   fpc_note_t notes[$];
   string names[12] = '{"doc", "dsr", "ccr", "mode", "cfg", "lock", "tim", "irq", "mot", "enc", "oe", "host"};
   int miscompares = 0, n_tests = 0, cyc = 0;
   event chk_ev;
   fpc_pin_ctrl u_dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .bus_mode_strap_in(strap),
      .encoding_pin_in(enc_in), .encoding_pin_out(enc_out), .encoding_pin_oe_out(enc_oe),
      .doc_write_in(we[0]), .doc_data_in(wd), .dsr_write_in(we[1]), .dsr_data_in(wd),
      .ccr_write_in(we[2]), .ccr_data_in(wd), .mode_write_in(we[3]), .mode_data_in(wd),
      .cfg_write_in(we[4]), .cfg_data_in(wd), .lock_write_in(we[5]), .lock_data_in(wd[0]),
      .timing_write_in(we[6]), .timing_data_in(wd), .function_enable_in(fe), .exec_done_in(exd),
      .xfer_ready_in(xrdy), .non_dma_in(ndma), .double_density_in(dd), .diag_in(diag),
      .controller_interrupt_out(irq), .motor_enable_b_out(mot_b), .drive_output_control_out(doc),
      .data_rate_select_out(dsr), .configuration_control_out(configuration_control_reg), .mode_params_out(mpar),
      .config_params_out(cpar), .lock_out(lock), .timing_params_out(tpar), .host_mode_out(hmode));
   fpc_strap_model u_strap (.pull_high_in(pull), .encoding_pin_out(enc_out), .encoding_pin_oe_out(enc_oe),
      .encoding_pin_in(enc_in));
   // Clock
   initial begin
      forever #5 clk_sys_in = ~clk_sys_in;
   end
   // Hang guard
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 3000) begin
         miscompares++;
         give_verdict();
      end
   end
   function automatic logic [7:0] obs(int id);
      logic [7:0] o[12];
      o = '{doc, dsr, configuration_control_reg, mpar, cpar, {7'h0, lock}, tpar, {7'h0, irq}, {6'h0, mot_b}, {7'h0, enc_out},
         {7'h0, enc_oe}, 8'(hmode)};
      return o[id];
   endfunction
   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic tick(int n);
      repeat (n) @(negedge clk_sys_in);
   endtask
   // Note an expectation and hand it to the watcher
   task automatic chk(int id, logic [7:0] exp);
      notes.push_back('{id, exp});
      ->chk_ev;
   endtask
   // One-cycle write strobe on register r, then an idle edge so strobes never abut
   task automatic wr(int r, logic [7:0] v);
      we = 7'h01 << r;
      wd = v;
      tick(1);
      we = 7'h00;
      tick(1);
   endtask
   task automatic do_reset(logic s, logic p, fpc_host_mode_t hm);
      rst_b_in = 1'b0;
      strap = s;
      pull = p;
      tick(8);
      chk(7, 8'h00);
      chk(8, 8'h03);
      chk(10, 8'h00);
      rst_b_in = 1'b1;
      tick(4);
      strap = ~s;
      pull = ~p;
      tick(4);
      chk(11, 8'(hm));
   endtask
   // Watcher: oldest note against the outputs
   always begin
      fpc_note_t n;
      @(chk_ev);
      while (notes.size() > 0) begin
         n = notes.pop_front();
         n_tests++;
         if (obs(n.id) !== n.exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", names[n.id], n.exp, obs(n.id));
         end
      end
   end
   // Main sequence
   initial begin
      logic [7:0] v;
      logic [1:0] s;
      void'($urandom(32'h8580ddbc));
      do_reset(1'b1, 1'b1, FPC_CLASSIC);
      for (int m = 0; m < 3; m++) begin
         for (int r = 0; r < 7; r++) begin
            v = $urandom;
            wr(r, v);
         end
         do_reset(m == 0, m == 2, fpc_host_mode_t'(m));
         for (int r = 0; r < 6; r++) begin
            chk(r, dflt[r]);
         end
         chk(6, v);
         chk(10, 8'h01);
         chk(9, 8'h00);
         for (int b = 0; b < 2; b++) begin
            wr(0, b ? 8'h0c : 8'h04);
            tick(1);
            exd = 1'b1;
            tick(2);
            chk(7, {7'h0, b[0] | (m == 2)});
            exd = 1'b0;
            ndma = 1'b1;
            xrdy = 1'b1;
            tick(2);
            chk(7, {7'h0, b[0] | (m == 2)});
            xrdy = 1'b0;
            tick(2);
            chk(7, 8'h00);
         end
      end
      for (int k = 0; k < 2; k++) begin
         wr(3, {7'h00, k[0]});
         for (int i = 0; i < 4; i++) begin
            {dd, diag} = 2'($urandom);
            tick(2);
            chk(9, {7'h00, k ? diag : dd});
         end
      end
      for (int i = 0; i < 16; i++) begin
         v = $urandom;
         fe = {3'h0, 1'($urandom), 4'h0};
         wr(0, v);
         tick(1);
         s = v[1:0];
         chk(8, {6'h00, fe[4] ? (v[4 + s] ? ~s : 2'b11) : ~v[5:4]});
      end
      give_verdict();
   end
endmodule
